// *** rtl/pcg_top.sv ***
// Glue around PWM, capture and encoder modules with an AXI4-Lite slave.
// Assumes one 25 MHz peripheral clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_top #(
   parameter int NPWM = 7,
   parameter int NCAP = 6,
   parameter int NTRIP = 3,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // PWM clocking and sync
   output logic [NPWM-1:0] o_pwm_clock_gate,
   output logic [NPWM-1:0] o_timebase_clock_run,
   input wire logic i_first_pwm_sync_pulse,
   output logic o_first_pwm_sync_out,
   // Trip inputs to PWM modules
   input wire logic [NTRIP-1:0] i_trip_input_low,
   output logic [NTRIP-1:0] o_trip_input_low,
   input wire logic i_encoder_one_phase_fault,
   input wire logic i_encoder_two_phase_fault,
   output logic [NPWM-1:0] o_encoder_fault_trip_low,
   input wire logic i_osc_fail_event,
   input wire logic i_pll_slip_event,
   output logic o_clock_fail_trip_low,
   input wire logic i_cpu_debug_halt,
   output logic o_debug_halt_trip_low,
   // Capture modules
   output logic [NCAP-1:0] o_capture_clock_gate,
   input wire logic [NCAP-1:0] i_capture_pin,
   output logic [NCAP-1:0] o_capture_pin,
   output logic [NCAP-1:0] o_capture_pin_oe,
   output logic [NCAP-1:0] o_capture_in,
   input wire logic [NCAP-1:0] i_capture_aux_pwm
);
   if (NPWM != 7 || NCAP != 6 || NTRIP != 3 || ADDR_W < 8) begin : g_bad
      $error("pcg_top: register layout needs 7 PWM, 6 capture, 3 trip");
   end

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic align;
      logic [6:0] pwm_gate;
      logic [5:0] cap_gate;
      logic [6:0][2:0] enc_sel;
      logic [5:0][2:0] cap_sel;
      logic [2:0][2:0] trip_sel;
      logic osc_flag;
      logic pll_flag;
      logic [5:0] aux_en;
      logic [6:0] pwm_en_out;
      logic [6:0] tb_run;
      logic [5:0] cap_en_out;
      logic [6:0] enc_trip;
      logic clk_trip;
      logic dbg_trip;
      logic [5:0] cap_in;
      logic [5:0] cap_pin;
      logic [5:0] cap_oe;
   } pcg_st_t;

   pcg_st_t st_q, st_d;
   logic [NTRIP-1:0] trip_sync, trip_filt;
   logic [NCAP-1:0] cap_sync, cap_filt;
   logic sync_level;

   // Four 3-bit fields, one per byte lane
   function automatic logic [31:0] pack4(input logic [3:0][2:0] f);
      return {5'h00, f[3], 5'h00, f[2], 5'h00, f[1], 5'h00, f[0]};
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `PCG_OFS_AUX);
   endfunction

   function automatic logic [31:0] rd_word(input pcg_st_t s, input logic [7:0] a);
      logic [3:0][2:0] f;
      logic [31:0] r;
      f = '0;
      r = '0;
      if (a == `PCG_OFS_TB) begin
         for (int i = 1; i < 4; i++) f[i] = {2'h0, s.pwm_gate[i-1]};
         r = pack4(f);
         r[`PCG_BIT_ALIGN] = s.align;
      end else if (a == `PCG_OFS_PWMG) begin
         for (int i = 0; i < 4; i++) f[i] = {2'h0, s.pwm_gate[i+3]};
         r = pack4(f);
      end else if (a == `PCG_OFS_CAPGA) begin
         for (int i = 0; i < 4; i++) f[i] = {2'h0, s.cap_gate[i]};
         r = pack4(f);
      end else if (a == `PCG_OFS_CAPGB) begin
         for (int i = 0; i < 2; i++) f[i] = {2'h0, s.cap_gate[i+4]};
         r = pack4(f);
      end else if (a == `PCG_OFS_ENCA) begin
         for (int i = 0; i < 4; i++) f[i] = s.enc_sel[i];
         r = pack4(f);
      end else if (a == `PCG_OFS_ENCB) begin
         for (int i = 0; i < 3; i++) f[i] = s.enc_sel[i+4];
         r = pack4(f);
      end else if (a == `PCG_OFS_CSA) begin
         for (int i = 0; i < 4; i++) f[i] = s.cap_sel[i];
         r = pack4(f);
      end else if (a == `PCG_OFS_CSB) begin
         for (int i = 0; i < 2; i++) f[i] = s.cap_sel[i+4];
         r = pack4(f);
      end else if (a == `PCG_OFS_TSA) begin
         f[2] = s.trip_sel[0];
         f[3] = s.trip_sel[1];
         r = pack4(f);
      end else if (a == `PCG_OFS_TSB) begin
         f[0] = s.trip_sel[2];
         r = pack4(f);
      end else if (a == `PCG_OFS_CF) begin
         r[`PCG_BIT_OSC] = s.osc_flag;
         r[`PCG_BIT_PLL] = s.pll_flag;
      end else if (a == `PCG_OFS_AUX) begin
         r[5:0] = s.aux_en;
      end
      return r;
   endfunction

   function automatic pcg_pkg::pcg_path_t trip_path(input pcg_pkg::pcg_sel_t s);
      if (s == `PCG_SEL_SYNC) return pcg_pkg::PCG_PATH_SYNC;
      else if (s == `PCG_SEL_FILT) return pcg_pkg::PCG_PATH_FILT;
      else return pcg_pkg::PCG_PATH_ASYNC;
   endfunction

   always_comb begin
      logic [31:0] old;
      logic [31:0] msk;
      logic [31:0] nw;
      logic [31:0] clr;
      logic [7:0] ra;
      st_d = st_q;
      old = rd_word(st_q, st_q.waddr);
      msk = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}},
             {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
      nw = (old & ~msk) | (st_q.wdata & msk);
      clr = '0;
      ra = i_s_axi_araddr[7:0];
      // Write channels taken in either order
      if (i_s_axi_awvalid && st_q.awready) begin
         st_d.aw_have = 1'b1;
         st_d.waddr = i_s_axi_awaddr[7:0];
      end
      if (i_s_axi_wvalid && st_q.wready) begin
         st_d.w_have = 1'b1;
         st_d.wdata = i_s_axi_wdata;
         st_d.wstrb = i_s_axi_wstrb;
      end
      if (st_q.bvalid && i_s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
         st_d.aw_have = 1'b0;
         st_d.w_have = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = addr_ok(st_q.waddr) ? pcg_pkg::PCG_RESP_OKAY
                                          : pcg_pkg::PCG_RESP_SLVERR;
         if (st_q.waddr == `PCG_OFS_TB) begin
            st_d.align = nw[`PCG_BIT_ALIGN];
            for (int i = 1; i < 4; i++) st_d.pwm_gate[i-1] = nw[8*i];
         end else if (st_q.waddr == `PCG_OFS_PWMG) begin
            for (int i = 0; i < 4; i++) st_d.pwm_gate[i+3] = nw[8*i];
         end else if (st_q.waddr == `PCG_OFS_CAPGA) begin
            for (int i = 0; i < 4; i++) st_d.cap_gate[i] = nw[8*i];
         end else if (st_q.waddr == `PCG_OFS_CAPGB) begin
            for (int i = 0; i < 2; i++) st_d.cap_gate[i+4] = nw[8*i];
         end else if (st_q.waddr == `PCG_OFS_ENCA) begin
            for (int i = 0; i < 4; i++) st_d.enc_sel[i] = nw[8*i +: 3];
         end else if (st_q.waddr == `PCG_OFS_ENCB) begin
            for (int i = 0; i < 3; i++) st_d.enc_sel[i+4] = nw[8*i +: 3];
         end else if (st_q.waddr == `PCG_OFS_CSA) begin
            for (int i = 0; i < 4; i++) st_d.cap_sel[i] = nw[8*i +: 3];
         end else if (st_q.waddr == `PCG_OFS_CSB) begin
            for (int i = 0; i < 2; i++) st_d.cap_sel[i+4] = nw[8*i +: 3];
         end else if (st_q.waddr == `PCG_OFS_TSA) begin
            st_d.trip_sel[0] = nw[16 +: 3];
            st_d.trip_sel[1] = nw[24 +: 3];
         end else if (st_q.waddr == `PCG_OFS_TSB) begin
            st_d.trip_sel[2] = nw[2:0];
         end else if (st_q.waddr == `PCG_OFS_CF) begin
            clr = st_q.wdata & msk;
         end else if (st_q.waddr == `PCG_OFS_AUX) begin
            st_d.aux_en = nw[5:0];
         end
      end
      st_d.awready = !st_d.aw_have;
      st_d.wready = !st_d.w_have;
      // Read answers one cycle after the address is taken
      if (st_q.rvalid && i_s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (i_s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd_word(st_q, ra);
         st_d.rresp = addr_ok(ra) ? pcg_pkg::PCG_RESP_OKAY
                                  : pcg_pkg::PCG_RESP_SLVERR;
      end
      st_d.arready = !st_d.rvalid;
      st_d.osc_flag = (st_q.osc_flag & ~clr[`PCG_BIT_OSC]) | i_osc_fail_event;
      st_d.pll_flag = (st_q.pll_flag & ~clr[`PCG_BIT_PLL]) | i_pll_slip_event;
      st_d.clk_trip = !(st_q.osc_flag || st_q.pll_flag);
      st_d.dbg_trip = !i_cpu_debug_halt;
      st_d.pwm_en_out = st_q.pwm_gate;
      st_d.cap_en_out = st_q.cap_gate;
      st_d.tb_run = st_q.pwm_gate & {7{st_q.align}};
      for (int i = 0; i < 7; i++) begin
         if (st_q.enc_sel[i] == `PCG_ENC_ONE) begin
            st_d.enc_trip[i] = !i_encoder_one_phase_fault;
         end else if (st_q.enc_sel[i] == `PCG_ENC_TWO) begin
            st_d.enc_trip[i] = !i_encoder_two_phase_fault;
         end else begin
            st_d.enc_trip[i] = !(i_encoder_one_phase_fault ||
                                 i_encoder_two_phase_fault);
         end
      end
      for (int i = 0; i < 6; i++) begin
         st_d.cap_in[i] = (st_q.cap_sel[i] == `PCG_CAP_FILT) ? cap_filt[i]
                                                            : cap_sync[i];
         st_d.cap_pin[i] = st_q.aux_en[i] & i_capture_aux_pwm[i];
         st_d.cap_oe[i] = st_q.aux_en[i];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.pwm_gate <= '1;
         st_q.cap_gate <= '1;
         st_q.pwm_en_out <= '1;
         st_q.cap_en_out <= '1;
         st_q.enc_sel <= {7{`PCG_ENC_OR}};
         st_q.cap_sel <= {6{`PCG_CAP_SYNC}};
         st_q.trip_sel <= {3{`PCG_SEL_ASYNC}};
         st_q.enc_trip <= '1;
         st_q.clk_trip <= 1'b1;
         st_q.dbg_trip <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   pcg_in_cond #(.W(NTRIP), .FILT(`PCG_FILT_CYC)) u_trip_cond (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_in(i_trip_input_low),
      .o_sync(trip_sync),
      .o_filt(trip_filt)
   );

   pcg_in_cond #(.W(NCAP), .FILT(`PCG_FILT_CYC), .IDLE(1'b0)) u_cap_cond (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_in(i_capture_pin),
      .o_sync(cap_sync),
      .o_filt(cap_filt)
   );

   pcg_stretch #(.LEN(`PCG_STRETCH_CYC)) u_sync_stretch (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pulse(i_first_pwm_sync_pulse),
      .o_level(sync_level)
   );

   // path mux; async must bypass every flop
   for (genvar t = 0; t < NTRIP; t++) begin : g_trip
      pcg_pkg::pcg_path_t p;
      assign p = trip_path(st_q.trip_sel[t]);
      assign o_trip_input_low[t] =
         (p == pcg_pkg::PCG_PATH_SYNC) ? trip_sync[t] :
         (p == pcg_pkg::PCG_PATH_FILT) ? trip_filt[t] : i_trip_input_low[t];
   end

   assign o_s_axi_awready = st_q.awready;
   assign o_s_axi_wready = st_q.wready;
   assign o_s_axi_bresp = st_q.bresp;
   assign o_s_axi_bvalid = st_q.bvalid;
   assign o_s_axi_arready = st_q.arready;
   assign o_s_axi_rdata = st_q.rdata;
   assign o_s_axi_rresp = st_q.rresp;
   assign o_s_axi_rvalid = st_q.rvalid;
   assign o_pwm_clock_gate = st_q.pwm_en_out;
   assign o_timebase_clock_run = st_q.tb_run;
   assign o_first_pwm_sync_out = sync_level;
   assign o_encoder_fault_trip_low = st_q.enc_trip;
   assign o_clock_fail_trip_low = st_q.clk_trip;
   assign o_debug_halt_trip_low = st_q.dbg_trip;
   assign o_capture_clock_gate = st_q.cap_en_out;
   assign o_capture_pin = st_q.cap_pin;
   assign o_capture_pin_oe = st_q.cap_oe;
   assign o_capture_in = st_q.cap_in;
endmodule // pcg_top
`default_nettype wire

// *** include/pcg_cfg.svh ***
// Constants for the PWM/capture glue block: offsets, codes, reset values.
// Assumes byte addressing on a 32-bit register bus.
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH
`define PCG_OFS_TB 8'h00
`define PCG_OFS_PWMG 8'h04
`define PCG_OFS_CAPGA 8'h08
`define PCG_OFS_CAPGB 8'h0C
`define PCG_OFS_ENCA 8'h10
`define PCG_OFS_ENCB 8'h14
`define PCG_OFS_CSA 8'h18
`define PCG_OFS_CSB 8'h1C
`define PCG_OFS_TSA 8'h20
`define PCG_OFS_TSB 8'h24
`define PCG_OFS_CF 8'h28
`define PCG_OFS_AUX 8'h2C
`define PCG_BIT_ALIGN 1
`define PCG_BIT_OSC 0
`define PCG_BIT_PLL 1
`define PCG_SEL_ASYNC 3'h1
`define PCG_SEL_SYNC 3'h2
`define PCG_SEL_FILT 3'h4
`define PCG_ENC_OR 3'h1
`define PCG_ENC_ONE 3'h2
`define PCG_ENC_TWO 3'h4
`define PCG_CAP_SYNC 3'h1
`define PCG_CAP_FILT 3'h2
`define PCG_STRETCH_CYC 8
`define PCG_FILT_CYC 6
`endif

// *** include/pcg_pkg.sv ***
// Shared types of the PWM/capture glue block.
// Assumes pcg_cfg.svh supplies the numeric constants.
package pcg_pkg;
   typedef logic [2:0] pcg_sel_t;
   typedef enum logic [1:0] {
      PCG_RESP_OKAY = 2'h0,
      PCG_RESP_SLVERR = 2'h2
   } pcg_resp_t;
   typedef enum logic [2:0] {
      PCG_PATH_ASYNC = 3'b001,
      PCG_PATH_SYNC = 3'b010,
      PCG_PATH_FILT = 3'b100
   } pcg_path_t;
endpackage

// *** rtl/pcg_in_cond.sv ***
// Double synchroniser plus stable-level filter, one lane per bit.
// Assumes inputs are plain levels; both outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module pcg_in_cond #(
   parameter int W = 1,
   parameter int FILT = 6,
   parameter bit IDLE = 1'b1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Data
   input wire logic [W-1:0] i_in,
   output logic [W-1:0] o_sync,
   output logic [W-1:0] o_filt
);
   localparam int CW = $clog2(FILT + 1);
   if (W < 1 || FILT < 1) begin : g_bad
      $error("pcg_in_cond: W and FILT must be positive");
   end
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] filt;
      logic [W-1:0][CW-1:0] cnt;
   } pcg_ic_t;
   pcg_ic_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = i_in;
      st_d.s2 = st_q.s1;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.filt[i]) begin
            st_d.cnt[i] = '0;
         end else if (st_q.cnt[i] == CW'(FILT - 1)) begin
            st_d.cnt[i] = '0;
            st_d.filt[i] = st_q.s2[i];
         end else begin
            st_d.cnt[i] = st_q.cnt[i] + CW'(1);
         end
      end
   end
   // Reset to the pin's idle level, so no false edge follows reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '{s1: {W{IDLE}}, s2: {W{IDLE}}, filt: {W{IDLE}}, cnt: '0};
      end else begin
         st_q <= st_d;
      end
   end
   assign o_sync = st_q.s2;
   assign o_filt = st_q.filt;
endmodule // pcg_in_cond
`default_nettype wire

// *** rtl/pcg_stretch.sv ***
// Pulse stretcher: holds its output high LEN cycles after a pulse.
// Assumes a synchronous input pulse; a new pulse restarts the count.
`timescale 1ns/1ps
`default_nettype none
module pcg_stretch #(
   parameter int LEN = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pulse in, stretched level out
   input wire logic i_pulse,
   output logic o_level
);
   localparam int CW = $clog2(LEN + 1);
   if (LEN < 1) begin : g_bad
      $error("pcg_stretch: LEN must be positive");
   end
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic out;
   } pcg_sr_t;
   pcg_sr_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      if (i_pulse) begin
         st_d.cnt = CW'(LEN);
      end else if (st_q.cnt != '0) begin
         st_d.cnt = st_q.cnt - CW'(1);
      end
      st_d.out = (st_d.cnt != '0);
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign o_level = st_q.out;
endmodule // pcg_stretch
`default_nettype wire

// *** tb/pcg_asserts.sv ***
// Port-level checker for the PWM/capture glue block.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pcg_asserts #(
   parameter int NPWM = 7,
   parameter int NCAP = 6,
   parameter int NTRIP = 3
) (
   // Clock, reset, bus
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_s_axi_wvalid,
   // Watched ports
   input wire logic [NPWM-1:0] o_pwm_clock_gate,
   input wire logic [NPWM-1:0] o_timebase_clock_run,
   input wire logic i_first_pwm_sync_pulse,
   input wire logic o_first_pwm_sync_out,
   input wire logic [NTRIP-1:0] i_trip_input_low,
   input wire logic [NTRIP-1:0] o_trip_input_low,
   input wire logic i_encoder_one_phase_fault,
   input wire logic i_encoder_two_phase_fault,
   input wire logic [NPWM-1:0] o_encoder_fault_trip_low,
   input wire logic i_osc_fail_event,
   input wire logic i_pll_slip_event,
   input wire logic o_clock_fail_trip_low,
   input wire logic i_cpu_debug_halt,
   input wire logic o_debug_halt_trip_low,
   input wire logic [NCAP-1:0] o_capture_clock_gate
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   stretch_hold_a: assert property (
      i_first_pwm_sync_pulse |=> o_first_pwm_sync_out [*8])
      else $error("sync out too short");
   stretch_end_a: assert property (
      (i_first_pwm_sync_pulse ##1 !i_first_pwm_sync_pulse [*8]) |=> !o_first_pwm_sync_out)
      else $error("sync out too long");
   reset_vals_a: assert property (
      $rose(i_rst_n) |-> &o_pwm_clock_gate && &o_capture_clock_gate &&
      o_timebase_clock_run == '0 && o_trip_input_low == i_trip_input_low)
      else $error("bad state after reset");
   tb_together_a: assert property (
      $changed(o_timebase_clock_run) |->
      o_timebase_clock_run == '0 || o_timebase_clock_run == o_pwm_clock_gate)
      else $error("time bases not started together");
   debug_trip_a: assert property (i_cpu_debug_halt |=> !o_debug_halt_trip_low)
      else $error("debug trip missing");
   clk_fail_set_a: assert property (
      (i_osc_fail_event || i_pll_slip_event) |-> ##2 !o_clock_fail_trip_low)
      else $error("clock fail trip missing");
   // A clear write reaches the trip output three cycles after wvalid
   clk_fail_hold_a: assert property (
      (!o_clock_fail_trip_low && !i_s_axi_wvalid && !$past(i_s_axi_wvalid) &&
      !$past(i_s_axi_wvalid, 2)) |=> !o_clock_fail_trip_low)
      else $error("clock fail trip not sticky");
   enc_idle_a: assert property (
      !(i_encoder_one_phase_fault || i_encoder_two_phase_fault) |=> &o_encoder_fault_trip_low)
      else $error("encoder trip without fault");
   enc_both_a: assert property (
      (i_encoder_one_phase_fault && i_encoder_two_phase_fault) |=> !(|o_encoder_fault_trip_low))
      else $error("encoder trip missing");
   cover property (i_first_pwm_sync_pulse);
   cover property ($rose(o_timebase_clock_run[0]));
   cover property ($fell(o_clock_fail_trip_low));
endmodule // pcg_asserts
bind pcg_top pcg_asserts #(.NPWM(NPWM), .NCAP(NCAP), .NTRIP(NTRIP)) pcg_asserts_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_pwm_clock_gate(o_pwm_clock_gate), .o_timebase_clock_run(o_timebase_clock_run),
   .i_first_pwm_sync_pulse(i_first_pwm_sync_pulse), .o_first_pwm_sync_out(o_first_pwm_sync_out),
   .i_trip_input_low(i_trip_input_low), .o_trip_input_low(o_trip_input_low),
   .i_encoder_one_phase_fault(i_encoder_one_phase_fault),
   .i_encoder_two_phase_fault(i_encoder_two_phase_fault),
   .o_encoder_fault_trip_low(o_encoder_fault_trip_low), .i_osc_fail_event(i_osc_fail_event),
   .i_pll_slip_event(i_pll_slip_event), .o_clock_fail_trip_low(o_clock_fail_trip_low),
   .i_cpu_debug_halt(i_cpu_debug_halt), .o_debug_halt_trip_low(o_debug_halt_trip_low),
   .o_capture_clock_gate(o_capture_clock_gate));
`default_nettype wire

// *** tb/pcg_far_model.sv ***
// Model of the PWM, encoder and capture modules beside the glue block.
// Assumes the bench requests sync pulses and fault levels.
`timescale 1ns/1ps
`default_nettype none
module pcg_far_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bench commands
   input wire logic i_fire,
   input wire logic [1:0] i_fault,
   // Towards the glue block
   output logic o_sync_pulse,
   output logic o_enc_one,
   output logic o_enc_two,
   output logic [5:0] o_aux_pwm
);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sync_pulse <= 1'h0;
         o_enc_one <= 1'h0;
         o_enc_two <= 1'h0;
         o_aux_pwm <= 6'h00;
      end else begin
         o_sync_pulse <= i_fire;
         o_enc_one <= i_fault[0];
         o_enc_two <= i_fault[1];
         // Bit 0 toggles every cycle, so a stale copy shows
         o_aux_pwm <= o_aux_pwm + 6'h01;
      end
   end
endmodule // pcg_far_model
`default_nettype wire

// *** tb/pcg_top_tb.sv ***
// Self-checking bench for the glue block over AXI4-Lite.
// Assumes the far model and the port checker beside it.
`timescale 1ns/1ps
`default_nettype none
module pcg_top_tb;
   logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdata;
   logic awr, wr_r, bv, arr, rv, sp, so, e1, e2, cft, dbt, osc = 1'h0, pll = 1'h0;
   logic halt = 1'h0, fire = 1'h0, e0;
   logic [1:0] br, rr, fault = 2'h0;
   logic [6:0] gate, run, enct;
   logic [2:0] ti = 3'h7, to;
   logic [5:0] cg, cp = 6'h00, po, poe, ci, aux, a;
   logic [33:0] exp_q[$];
   logic [31:0] rvt [12] = '{32'h01010100, 32'h01010101, 32'h01010101, 32'h00000101,
      32'h01010101, 32'h00010101, 32'h01010101, 32'h00000101, 32'h01010000, 32'h00000001,
      32'h0, 32'h0};
   bit pc [8] = '{0, 0, 0, 0, 0, 1, 1, 1};
   logic [2:0] pk [8] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h3, 3'h1, 3'h2, 3'h2};
   int ph [8] = '{4, 4, 3, 12, 4, 4, 3, 12};
   int plo [8] = '{0, 2, -1, 6, 0, 2, -1, 6};
   int phi [8] = '{0, 3, -1, 11, 0, 4, -1, 12};
   logic [2:0] ek [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
   int error_cnt = 0, n_checks = 0, cyc = 0, seed = 62, lat;
   pcg_top pcg_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(brdy), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy),
      .o_pwm_clock_gate(gate), .o_timebase_clock_run(run), .i_first_pwm_sync_pulse(sp),
      .o_first_pwm_sync_out(so), .i_trip_input_low(ti), .o_trip_input_low(to),
      .i_encoder_one_phase_fault(e1), .i_encoder_two_phase_fault(e2),
      .o_encoder_fault_trip_low(enct), .i_osc_fail_event(osc), .i_pll_slip_event(pll),
      .o_clock_fail_trip_low(cft), .i_cpu_debug_halt(halt), .o_debug_halt_trip_low(dbt),
      .o_capture_clock_gate(cg), .i_capture_pin(cp), .o_capture_pin(po),
      .o_capture_pin_oe(poe), .o_capture_in(ci), .i_capture_aux_pwm(aux));
   pcg_far_model pcg_far_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire),
      .i_fault(fault), .o_sync_pulse(sp), .o_enc_one(e1), .o_enc_two(e2), .o_aux_pwm(aux));
   always #20 clk = ~clk;
   task automatic conclude();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic in_rng(input int v, input int lo, input int hi);
      n_checks++;
      if (v < lo || v > hi) begin
         error_cnt++;
         $display("BAD %0t input path latency %0d", $time, v);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Both channels offered together, each released when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      awa <= ad;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      brdy <= 1'h1;
      do begin
         @(posedge clk);
         if (awr === 1'h1) awv <= 1'h0;
         if (wr_r === 1'h1) wv <= 1'h0;
      end while (awv || wv || bv !== 1'h1);
      cmp(34'(br), (ad > 8'h2C || ad[1:0] != 2'h0) ? 34'h2 : 34'h0, "bresp");
      brdy <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] e);
      exp_q.push_back(e);
      ara <= ad;
      arv <= 1'h1;
      rrdy <= 1'h1;
      do begin
         @(posedge clk);
         if (arr === 1'h1) arv <= 1'h0;
      end while (rv !== 1'h1);
      rrdy <= 1'h0;
      @(posedge clk);
   endtask
   // Pulse on trip 0 (low) or capture pin 0 (high); first cycle seen
   task automatic probe(input bit cap, input int hold, output int l);
      l = -1;
      for (int k = 0; k < 20; k++) begin
         if (cap) cp[0] <= (k < hold);
         else ti[0] <= (k >= hold);
         #2;
         if (l < 0 && (cap ? ci[0] === 1'h1 : to[0] === 1'h0)) l = k;
         @(posedge clk);
      end
      tick(12);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         error_cnt++;
         conclude();
      end
      if (rv === 1'h1 && rrdy === 1'h1) cmp({rr, rdata}, exp_q.pop_front(), "read");
   end
   initial begin
      tick(4);
      rst_n <= 1'h1;
      @(posedge clk);
      foreach (rvt[i]) rd(8'(i * 4), {2'h0, rvt[i]});
      rd(8'h30, {2'h2, 32'h0});
      rd(8'h02, {2'h2, 32'h0});
      wr(8'h30, 32'hFFFFFFFF);
      wr(8'h00, 32'h01010102);
      tick(3);
      cmp(34'(run), 34'h7F, "run all");
      wr(8'h04, 32'h01010100);
      tick(3);
      cmp(34'({gate, run}), 34'({7'h77, 7'h77}), "pwm gate");
      wr(8'h00, 32'h01010100);
      tick(3);
      cmp(34'(run), 34'h0, "run stop");
      wr(8'h04, 32'h01010101);
      wr(8'h08, 32'h01010001);
      tick(3);
      cmp(34'(cg), 34'h3D, "capture gate");
      wr(8'h08, 32'h01010101);
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
      lat = 0;
      repeat (14) begin
         @(posedge clk);
         #2;
         lat += int'(so === 1'h1);
      end
      in_rng(lat, 8, 8);
      foreach (pk[i]) begin
         if (pc[i]) wr(8'h18, 32'h01010100 | 32'(pk[i]));
         else wr(8'h20, 32'h01000000 | (32'(pk[i]) << 16));
         probe(pc[i], ph[i], lat);
         in_rng(lat, plo[i], phi[i]);
      end
      foreach (ek[i]) begin
         wr(8'h10, 32'h01010100 | 32'(ek[i]));
         repeat (4) begin
            fault <= 2'($random(seed));
            tick(4);
            e0 = (ek[i] == 3'h2) ? fault[0] : (ek[i] == 3'h4) ? fault[1] : |fault;
            cmp(34'(enct), 34'({{6{~|fault}}, ~e0}), "encoder trip");
         end
      end
      for (int j = 0; j < 2; j++) begin
         if (j == 0) osc <= 1'h1;
         else pll <= 1'h1;
         @(posedge clk);
         osc <= 1'h0;
         pll <= 1'h0;
         tick(8);
         cmp(34'(cft), 34'h0, "clock fail set");
         rd(8'h28, 34'(1 << j));
         wr(8'h28, 32'h3);
         tick(3);
         cmp(34'(cft), 34'h1, "clock fail clear");
      end
      halt <= 1'h1;
      tick(3);
      cmp(34'(dbt), 34'h0, "debug trip");
      halt <= 1'h0;
      tick(3);
      cmp(34'(dbt), 34'h1, "debug idle");
      wr(8'h2C, 32'h21);
      tick(3);
      a = aux;
      #2;
      cmp(34'({poe, po & 6'h21}), 34'({6'h21, a & 6'h21}), "aux pwm");
      conclude();
   end
endmodule // pcg_top_tb
`default_nettype wire
